// file: rtl/front_panel_mode_controller.sv
/*
  Front panel mode controller: key decoding, mode and range stepping, per range zero
  correction, peak hold tracking and status message selection.
  Assumes key and probe status pins are asynchronous, and samples come from same-clock logic.
*/
// Operation
// - Keys take effect on release, never on press.
// - Lone mode release steps dc, ac, peak, peak ac, temperature, dc.
// - Lone range release steps through four ranges, wrapping, mode unchanged.
// - Single-range probe makes a lone range release do nothing; chords with the range key still act.
// - Both keys released outside peak hold zero the range, show zero message.
// - Hold one key, tap the other twice, also zeroes.
// - In peak hold the chord resets the held peak instead.
// - Peak hold shows largest magnitude of the current polarity since entry, reset or polarity change.
// - Polarity change restarts the held peak from the new reading.
// - With filtering on, peak tracker uses filtered value.
// - High-sensitivity probe divides every full scale by ten.
// - AC modes show letter A in the leftmost character.
// - Hold indicator lit whenever a peak hold mode is active.
// - Up to seven digits, minus sign for reverse polarity.
// - Over full scale shows over-range message while the corrected reading stays above full scale.
// - Power up or software restart shows maker message two seconds.
// - No probe shows probe-absent message and disables keys.
// - No sensor shows message after power up and on temperature mode.
// - Independent zero correction per range, dc and ac separately.
// - Over-range locks out every key except range selection.
module front_panel_mode_controller #(
  parameter longint unsigned MSG_CYCLES_P  = panel_pkg::MSG_CYCLES,
  parameter longint unsigned ZERO_CYCLES_P = panel_pkg::ZERO_CYCLES
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               mode_key_i,
  input  wire logic               range_key_i,
  input  wire logic               probe_present_i,
  input  wire logic               single_range_i,
  input  wire logic               high_sens_i,
  input  wire logic               temp_sensor_i,
  input  wire logic               filter_en_i,
  input  wire logic               restart_i,
  input  wire panel_pkg::sample_t sample_i,
  output panel_pkg::display_t     display_o
);

  logic [1:0] mode_sync;
  logic [1:0] range_sync;
  logic [1:0] probe_sync;
  logic [1:0] single_sync;
  logic [1:0] hs_sync;
  logic [1:0] temp_sync;
  logic [1:0] filt_sync;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_sync   <= 2'h0;
      range_sync  <= 2'h0;
      probe_sync  <= 2'h0;
      single_sync <= 2'h0;
      hs_sync     <= 2'h0;
      temp_sync   <= 2'h0;
      filt_sync   <= 2'h0;
    end
    else
    begin
      mode_sync   <= {mode_sync[0], mode_key_i};
      range_sync  <= {range_sync[0], range_key_i};
      probe_sync  <= {probe_sync[0], probe_present_i};
      single_sync <= {single_sync[0], single_range_i};
      hs_sync     <= {hs_sync[0], high_sens_i};
      temp_sync   <= {temp_sync[0], temp_sensor_i};
      filt_sync   <= {filt_sync[0], filter_en_i};
    end
  end

  wire mode_k  = mode_sync[1];
  wire range_k = range_sync[1];
  wire probe_ok = probe_sync[1];

  // Key decoder. A chord is remembered until both keys are up, so one key can be held
  // while the other is tapped: the second tap release completes the chord.
  panel_pkg::key_state_t key_state;
  panel_pkg::key_state_t next_key_state;
  logic                  last_mode;
  logic                  last_range;
  logic [1:0]            taps;
  logic [1:0]            next_taps;
  logic                  lone_mode;
  logic                  lone_range;
  logic                  chord;

  wire any_key = mode_k | range_k;
  wire mode_rel  = last_mode & ~mode_k;
  wire range_rel = last_range & ~range_k;

  always_comb
  begin
    next_key_state = key_state;
    next_taps = taps;
    lone_mode = 1'b0;
    lone_range = 1'b0;
    chord = 1'b0;
    case (key_state)
      panel_pkg::KEY_IDLE:
        if (mode_k & range_k)
          next_key_state = panel_pkg::KEY_CHORD;
        else if (any_key)
          next_key_state = panel_pkg::KEY_ONE;
      panel_pkg::KEY_ONE:
        if (mode_k & range_k)
        begin
          next_key_state = panel_pkg::KEY_CHORD;
          next_taps = 2'h0;
        end
        else if (!any_key)
        begin
          lone_mode = mode_rel;
          lone_range = range_rel;
          next_key_state = panel_pkg::KEY_IDLE;
        end
      panel_pkg::KEY_CHORD:
        if (!any_key)
        begin
          chord = 1'b1;
          next_key_state = panel_pkg::KEY_IDLE;
        end
        else if (mode_rel ^ range_rel)
        begin
          next_taps = taps + 2'h1;
          if (taps == 2'h1)
          begin
            chord = 1'b1;
            next_key_state = panel_pkg::KEY_WAIT;
          end
        end
      panel_pkg::KEY_WAIT:
        if (!any_key)
          next_key_state = panel_pkg::KEY_IDLE;
      default:
        next_key_state = panel_pkg::KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      key_state <= panel_pkg::KEY_IDLE;
      taps <= 2'h0;
      last_mode <= 1'b0;
      last_range <= 1'b0;
    end
    else
    begin
      key_state <= next_key_state;
      taps <= (key_state == panel_pkg::KEY_IDLE) ? 2'h0 : next_taps;
      last_mode <= mode_k;
      last_range <= range_k;
    end
  end

  panel_pkg::disp_mode_t mode;
  logic [1:0]            range_sel;
  logic signed [panel_pkg::FIELD_W-1:0] zero_tab [2*panel_pkg::NUM_RANGES];
  logic signed [panel_pkg::FIELD_W-1:0] peak;
  logic                  peak_neg;
  logic [31:0]           msg_cnt;
  panel_pkg::msg_t       timed_msg;
  logic                  pending_no_sensor;

  wire is_ac   = (mode == panel_pkg::MODE_AC) | (mode == panel_pkg::MODE_PEAK_AC);
  wire is_peak = (mode == panel_pkg::MODE_PEAK) | (mode == panel_pkg::MODE_PEAK_AC);
  wire [2:0] zero_idx = {is_ac, range_sel};

  wire signed [panel_pkg::FIELD_W-1:0] src =
    filt_sync[1] ? sample_i.filtered : sample_i.raw;
  wire signed [panel_pkg::FIELD_W-1:0] corr = src - zero_tab[zero_idx];
  wire corr_neg = corr[panel_pkg::FIELD_W-1];
  wire [panel_pkg::FIELD_W-1:0] corr_mag = corr_neg ? -corr : corr;

  wire [panel_pkg::FIELD_W-1:0] fs_norm =
    (range_sel == 2'h0) ? panel_pkg::FS_R0 :
    (range_sel == 2'h1) ? panel_pkg::FS_R1 :
    (range_sel == 2'h2) ? panel_pkg::FS_R2 : panel_pkg::FS_R3;
  wire [panel_pkg::FIELD_W-1:0] fs = hs_sync[1] ? fs_norm / 24'h00000A : fs_norm;
  // Over-range is judged on the corrected reading, so a large zero offset shifts it.
  wire over_range = (mode != panel_pkg::MODE_TEMP) & (corr_mag > fs);

  wire keys_live = probe_ok & (timed_msg != panel_pkg::MSG_POWER_UP);
  wire do_mode  = keys_live & lone_mode & ~over_range;
  wire do_range = keys_live & lone_range & ~single_sync[1];
  wire do_chord = keys_live & chord & ~over_range;
  wire do_zero  = do_chord & ~is_peak;
  wire peak_clr = (do_chord & is_peak) | do_mode;

  panel_pkg::disp_mode_t next_mode;
  always_comb
  begin
    case (mode)
      panel_pkg::MODE_DC:      next_mode = panel_pkg::MODE_AC;
      panel_pkg::MODE_AC:      next_mode = panel_pkg::MODE_PEAK;
      panel_pkg::MODE_PEAK:    next_mode = panel_pkg::MODE_PEAK_AC;
      panel_pkg::MODE_PEAK_AC: next_mode = panel_pkg::MODE_TEMP;
      panel_pkg::MODE_TEMP:    next_mode = panel_pkg::MODE_DC;
      default:                 next_mode = panel_pkg::MODE_DC;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= panel_pkg::MODE_DC;
      range_sel <= panel_pkg::RANGE_RESET;
    end
    else
    begin
      if (do_mode)
        mode <= next_mode;
      if (do_range)
        range_sel <= range_sel + 2'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2*panel_pkg::NUM_RANGES; gi++)
    begin : g_zero
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          zero_tab[gi] <= '0;
        else if (do_zero && sample_i.valid && zero_idx == 3'(gi))
          zero_tab[gi] <= src;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peak <= '0;
      peak_neg <= 1'b0;
    end
    else if (peak_clr)
    begin
      peak <= '0;
      peak_neg <= 1'b0;
    end
    else if (sample_i.valid && is_peak)
    begin
      if (corr_neg != peak_neg)
      begin
        peak <= signed'(corr_mag);
        peak_neg <= corr_neg;
      end
      else if (signed'(corr_mag) > peak)
        peak <= signed'(corr_mag);
    end
  end

  // Timed messages: power up, then no-sensor, zero done. The restart input reuses the
  // power-up path so both starts behave alike.
  wire msg_done = (msg_cnt == 32'h00000000);
  wire temp_sel = do_mode & (next_mode == panel_pkg::MODE_TEMP) & ~temp_sync[1];

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timed_msg <= panel_pkg::MSG_POWER_UP;
      msg_cnt <= 32'(MSG_CYCLES_P - 1);
      pending_no_sensor <= 1'b1;
    end
    else if (restart_i)
    begin
      timed_msg <= panel_pkg::MSG_POWER_UP;
      msg_cnt <= 32'(MSG_CYCLES_P - 1);
      pending_no_sensor <= 1'b1;
    end
    else if (temp_sel)
    begin
      timed_msg <= panel_pkg::MSG_NO_SENSOR;
      msg_cnt <= 32'(MSG_CYCLES_P - 1);
    end
    else if (do_zero)
    begin
      timed_msg <= panel_pkg::MSG_ZERO_DONE;
      msg_cnt <= 32'(ZERO_CYCLES_P - 1);
    end
    else if (!msg_done)
      msg_cnt <= msg_cnt - 32'h00000001;
    else if (timed_msg == panel_pkg::MSG_POWER_UP && pending_no_sensor && !temp_sync[1])
    begin
      timed_msg <= panel_pkg::MSG_NO_SENSOR;
      msg_cnt <= 32'(MSG_CYCLES_P - 1);
      pending_no_sensor <= 1'b0;
    end
    else
    begin
      timed_msg <= panel_pkg::MSG_NONE;
      pending_no_sensor <= 1'b0;
    end
  end

  wire panel_pkg::msg_t shown_msg =
    !probe_ok ? panel_pkg::MSG_PROBE_ABSENT :
    (timed_msg == panel_pkg::MSG_POWER_UP) ? panel_pkg::MSG_POWER_UP :
    over_range ? panel_pkg::MSG_OVER_RANGE : timed_msg;

  wire [panel_pkg::FIELD_W-1:0] shown_mag = is_peak ? peak : corr_mag;
  wire shown_neg = is_peak ? peak_neg : corr_neg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      display_o <= '{mode: panel_pkg::MODE_DC, msg: panel_pkg::MSG_POWER_UP, default: '0};
    else
    begin
      display_o.mode <= mode;
      display_o.msg <= shown_msg;
      display_o.ac_letter <= is_ac;
      display_o.hold_led <= is_peak;
      display_o.minus <= shown_neg & (shown_mag != '0);
      display_o.magnitude <= shown_mag;
      display_o.range_led <= 4'h1 << range_sel;
    end
  end

endmodule

// file: rtl/panel_pkg.sv
/*
  Shared types and constants for the front panel mode controller.
  Assumes a single 250 MHz system clock and readings delivered as signed integers.
*/
package panel_pkg;

  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned MSG_TIME_MS   = 2000;
  localparam int unsigned ZERO_TIME_MS  = 500;
  localparam longint unsigned MSG_CYCLES  = longint'(CLK_HZ) * MSG_TIME_MS / 1000;
  localparam longint unsigned ZERO_CYCLES = longint'(CLK_HZ) * ZERO_TIME_MS / 1000;

  localparam int FIELD_W = 24;
  localparam int NUM_RANGES = 4;
  localparam int DIGITS = 7;

  // Full scale in units of 0.1 mT, normal probe; high sensitivity divides by ten.
  localparam logic [23:0] FS_R0 = 24'h000BB8;
  localparam logic [23:0] FS_R1 = 24'h001770;
  localparam logic [23:0] FS_R2 = 24'h002EE0;
  localparam logic [23:0] FS_R3 = 24'h007530;

  localparam logic [1:0] RANGE_RESET = 2'h0;

  typedef enum logic [4:0] {
    MODE_DC      = 5'h01,
    MODE_AC      = 5'h02,
    MODE_PEAK    = 5'h04,
    MODE_PEAK_AC = 5'h08,
    MODE_TEMP    = 5'h10
  } disp_mode_t;

  typedef enum logic [3:0] {
    KEY_IDLE  = 4'h1,
    KEY_ONE   = 4'h2,
    KEY_CHORD = 4'h4,
    KEY_WAIT  = 4'h8
  } key_state_t;

  typedef enum logic [2:0] {
    MSG_NONE        = 3'h0,
    MSG_POWER_UP    = 3'h1,
    MSG_NO_SENSOR   = 3'h2,
    MSG_ZERO_DONE   = 3'h3,
    MSG_OVER_RANGE  = 3'h4,
    MSG_PROBE_ABSENT = 3'h5
  } msg_t;

  typedef struct packed {
    logic                      valid;
    logic signed [FIELD_W-1:0] raw;
    logic signed [FIELD_W-1:0] filtered;
  } sample_t;

  typedef struct packed {
    disp_mode_t                mode;
    msg_t                      msg;
    logic                      ac_letter;
    logic                      hold_led;
    logic                      minus;
    logic [FIELD_W-1:0]        magnitude;
    logic [3:0]                range_led;
  } display_t;

endpackage

// file: testbench/front_panel_mode_controller_assertions.sv
/*
  Port checker for the front panel mode controller.
  Assumes one clock domain and a range indicator that is one-hot per range.
*/
module panel_checker (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic                mode_key_i,
  input wire logic                range_key_i,
  input wire logic                probe_present_i,
  input wire logic                single_range_i,
  input wire panel_pkg::display_t display_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  function automatic logic [4:0] succ(input logic [4:0] m);
    return (m == 5'h10) ? 5'h01 : {m[3:0], 1'b0};
  endfunction

  function automatic logic [3:0] rot(input logic [3:0] r);
    return {r[2:0], r[3]};
  endfunction

  // Six quiet cycles flush any earlier mode release out of the synchroniser.
  sequence mode_quiet;
    !mode_key_i [*6];
  endsequence

  sequence lone_range_release;
    mode_quiet ##0 $fell(range_key_i);
  endsequence

  a_press_no_effect: assert property (mode_key_i [*5] |-> $stable(display_o.mode))
    else $error("mode moved while the mode key was held");
  a_mode_order: assert property ($changed(display_o.mode) |->
    display_o.mode == succ($past(display_o.mode)))
    else $error("mode stepped out of order");
  a_range_keeps_mode: assert property (lone_range_release |->
    ##1 $stable(display_o.mode) [*6])
    else $error("range key changed the mode");
  a_range_rotates: assert property ($changed(display_o.range_led) &&
    $past(display_o.range_led) != 4'h0 |-> display_o.range_led == rot($past(display_o.range_led)))
    else $error("range indicator skipped");
  a_single_range: assert property (single_range_i [*8] |-> $stable(display_o.range_led))
    else $error("range moved with a single range probe");
  a_ac_letter: assert property (display_o.ac_letter ==
    (display_o.mode inside {panel_pkg::MODE_AC, panel_pkg::MODE_PEAK_AC}))
    else $error("ac letter disagrees with mode");
  a_hold_lamp: assert property (display_o.hold_led ==
    (display_o.mode inside {panel_pkg::MODE_PEAK, panel_pkg::MODE_PEAK_AC}))
    else $error("hold lamp disagrees with mode");
  a_absent_msg: assert property (!probe_present_i [*5] |->
    display_o.msg == panel_pkg::MSG_PROBE_ABSENT)
    else $error("probe absent message missing");
endmodule

bind front_panel_mode_controller panel_checker i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_key_i(mode_key_i), .range_key_i(range_key_i),
  .probe_present_i(probe_present_i), .single_range_i(single_range_i), .display_o(display_o));

// file: testbench/panel_keys.sv
/*
  Model of the two front panel keys, worked through its tasks.
  Assumes keys read high while pressed; it changes them just after a rising edge.
*/
module panel_keys (
  input  wire logic clk_i,
  output logic      mode_key_o,
  output logic      range_key_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    mode_key_o = 1'b0;
    range_key_o = 1'b0;
  end

  task automatic set(input logic m, input logic r, input int wait_n);
    @(posedge clk_i);
    #1;
    mode_key_o = m;
    range_key_o = r;
    repeat (wait_n) @(posedge clk_i);
  endtask

  // Both keys go up together; 8 idle cycles let the release reach the display.
  task automatic tap(input logic m, input logic r);
    set(m, r, 4);
    set(1'b0, 1'b0, 8);
  endtask

  // Mode held while range is tapped twice, the slow form of the chord.
  task automatic hold_tap2;
    set(1'b1, 1'b0, 4);
    set(1'b1, 1'b1, 4);
    set(1'b1, 1'b0, 4);
    set(1'b1, 1'b1, 4);
    set(1'b1, 1'b0, 4);
    set(1'b0, 1'b0, 8);
  endtask
endmodule

// file: testbench/test_front_panel_mode_controller.sv
/*
  Self-checking bench for the front panel mode controller.
  Assumes short message counts and readings in the display's own units.
*/
module test_front_panel_mode_controller;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk_sys_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                probe = 1'b1;
  logic                single = 1'b0;
  logic                hsens = 1'b0;
  logic                restart = 1'b0;
  logic                filt = 1'b0;
  logic                temp = 1'b0;
  panel_pkg::sample_t  smp = '0;
  panel_pkg::display_t disp;
  wire logic           mk;
  wire logic           rk;
  logic [4:0]          em = 5'h01;
  int                  er = 0;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  i;
  int                  v;

  always #2 clk_sys_i = ~clk_sys_i;

  panel_keys i_keys (.clk_i(clk_sys_i), .mode_key_o(mk), .range_key_o(rk));

  front_panel_mode_controller #(.MSG_CYCLES_P(20), .ZERO_CYCLES_P(10)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_key_i(mk), .range_key_i(rk),
    .probe_present_i(probe), .single_range_i(single), .high_sens_i(hsens),
    .temp_sensor_i(temp), .filter_en_i(filt), .restart_i(restart),
    .sample_i(smp), .display_o(disp));

  function automatic logic [23:0] fs(input int r);
    return (r == 0) ? panel_pkg::FS_R0 : (r == 1) ? panel_pkg::FS_R1 :
           (r == 2) ? panel_pkg::FS_R2 : panel_pkg::FS_R3;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_msg(input panel_pkg::msg_t m);
    int k;
    k = 0;
    while (disp.msg !== m && k < 400)
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    check(disp.msg, m);
    // A message that never arrived ends the run here, counted as a mismatch.
    if (disp.msg !== m)
      stop_test();
  endtask

  // Raw and filtered differ so that the source in use shows at the display.
  task automatic put(input int r, input int f);
    @(posedge clk_sys_i);
    #1;
    smp = '{valid: 1'b1, raw: r[23:0], filtered: f[23:0]};
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic range_tap;
    i_keys.tap(1'b0, 1'b1);
    er = (er + 1) % 4;
  endtask

  initial
  begin
    void'($urandom(60458));
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check(disp.msg, panel_pkg::MSG_POWER_UP);
    wait_msg(panel_pkg::MSG_NO_SENSOR);
    wait_msg(panel_pkg::MSG_NONE);
    for (i = 0; i < 5; i++)
    begin
      i_keys.tap(1'b1, 1'b0);
      em = (em == 5'h10) ? 5'h01 : {em[3:0], 1'b0};
      check(disp.mode, em);
      if (em == 5'h10)
        check(disp.msg, panel_pkg::MSG_NO_SENSOR);
    end
    $display("test modes done");
    v = 4 + $urandom_range(0, 5);
    for (i = 0; i < v; i++)
      range_tap();
    check(disp.range_led, 4'h1 << er);
    check(disp.mode, em);
    #1;
    single = 1'b1;
    i_keys.tap(1'b0, 1'b1);
    check(disp.range_led, 4'h1 << er);
    #1;
    single = 1'b0;
    $display("test ranges done");
    v = $urandom_range(1, 2999);
    put(-v, -v);
    check(disp.minus, 1'b1);
    check(disp.magnitude, v);
    if (er == 3)
      range_tap();
    put(fs(er) + 1, fs(er) + 1);
    wait_msg(panel_pkg::MSG_OVER_RANGE);
    i_keys.tap(1'b1, 1'b0);
    check(disp.mode, em);
    range_tap();
    check(disp.msg, panel_pkg::MSG_NONE);
    $display("test over range done");
    v = $urandom_range(1, 200);
    put(v, v);
    i_keys.tap(1'b1, 1'b1);
    check(disp.msg, panel_pkg::MSG_ZERO_DONE);
    put(v + 5, v + 5);
    check(disp.magnitude, 5);
    range_tap();
    check(disp.magnitude, v + 5);
    i_keys.hold_tap2();
    check(disp.msg, panel_pkg::MSG_ZERO_DONE);
    wait_msg(panel_pkg::MSG_NONE);
    check(disp.magnitude, 0);
    $display("test zeroing done");
    range_tap();
    #1;
    filt = 1'b1;
    i_keys.tap(1'b1, 1'b0);
    i_keys.tap(1'b1, 1'b0);
    put(7, 100);
    put(7, 300);
    put(7, 200);
    check(disp.hold_led, 1'b1);
    check(disp.magnitude, 300);
    i_keys.tap(1'b1, 1'b1);
    put(7, 200);
    check(disp.msg, panel_pkg::MSG_NONE);
    check(disp.magnitude, 200);
    put(7, -50);
    put(7, -20);
    check(disp.minus, 1'b1);
    check(disp.magnitude, 50);
    $display("test peak done");
    #1;
    probe = 1'b0;
    wait_msg(panel_pkg::MSG_PROBE_ABSENT);
    i_keys.tap(1'b1, 1'b0);
    check(disp.mode, panel_pkg::MODE_PEAK);
    #1;
    probe = 1'b1;
    i_keys.tap(1'b1, 1'b0);
    #1;
    hsens = 1'b1;
    put(fs(er) / 10 + 1, fs(er) / 10 + 1);
    wait_msg(panel_pkg::MSG_OVER_RANGE);
    @(posedge clk_sys_i);
    #1;
    restart = 1'b1;
    @(posedge clk_sys_i);
    #1;
    restart = 1'b0;
    wait_msg(panel_pkg::MSG_POWER_UP);
    wait_msg(panel_pkg::MSG_OVER_RANGE);
    // With a temperature sensor fitted the no-sensor message must stay away.
    temp = 1'b1;
    put(7, 7);
    @(posedge clk_sys_i);
    #1;
    restart = 1'b1;
    @(posedge clk_sys_i);
    #1;
    restart = 1'b0;
    wait_msg(panel_pkg::MSG_POWER_UP);
    repeat (24) @(posedge clk_sys_i);
    check(disp.msg, panel_pkg::MSG_NONE);
    i_keys.tap(1'b1, 1'b0);
    check(disp.mode, panel_pkg::MODE_TEMP);
    check(disp.msg, panel_pkg::MSG_NONE);
    $display("test status done");
    stop_test();
  end
endmodule
